// file: param_resp_builder.v
// Parameter report response builder with Wishbone settings registers
`timescale 1ns/100ps
`default_nettype none
`include "param_resp_map.vh"

module param_resp_builder (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // Query from the command decoder
    input wire query_i,
    input wire query_bad_i,
    // Response word stream
    output wire resp_valid_o,
    input wire resp_ready_i,
    output wire [31:0] resp_data_o,
    output wire resp_last_o
);

    localparam S_IDLE = 3'h0;
    localparam S_FIXED = 3'h1;
    localparam S_VAR = 3'h2;
    localparam S_PAD = 3'h3;
    localparam S_CSUM = 3'h4;

    // Settings registers and status counters
    reg [15:0] filt_cnt;
    reg [7:0] mac_flags;
    reg [14:0] vlan_flags;
    reg [31:0] link_set;
    reg [31:0] bcast_set;
    reg [31:0] cfg_flags;
    reg [15:0] mode_fc;
    reg [31:0] evt_ctrl;
    reg [31:0] csum;
    reg [31:0] resp_code;
    reg [31:0] mac_lo [0:7];
    reg [15:0] mac_hi [0:7];
    reg [15:0] tag [0:14];
    reg [7:0] sent_cnt;
    reg [7:0] refused_cnt;

    // Builder state
    reg [2:0] state;
    reg pending;
    reg [2:0] word_idx;
    reg [3:0] mac_idx;
    reg [2:0] mac_byte;
    reg [3:0] tag_idx;
    reg tag_byte;
    reg [1:0] pos;
    reg [23:0] acc;

    // Combinational helpers
    reg [5:0] mac_sum;
    reg [3:0] mac_n;
    reg [3:0] vlan_n;
    reg [15:0] mac_mask;
    reg [15:0] vlan_mask;
    reg [47:0] mac_cur;
    reg [15:0] tag_cur;
    reg [7:0] cur_byte;
    reg have_byte;
    reg push;
    reg [31:0] push_data;
    reg push_last;
    reg [31:0] next_rdata;
    integer i;

    wire fifo_ready;
    wire wb_req;
    wire wb_wr;
    wire step;
    wire [31:0] wr_val;

    assign wb_req = cyc_i & stb_i & ~ack_o;
    assign wb_wr = wb_req & we_i;
    assign step = ~push | fifo_ready;

    // Lane merge over the zero-extended read-back; narrow registers keep
    // only their own bits, so unused lanes can never leak into them
    assign wr_val = merge(next_rdata, dat_i, sel_i);

    // Byte-lane merge for partial writes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] val;
        input [3:0] sel;
        integer k;
        begin
            for (k = 0; k < 4; k = k + 1)
                merge[8*k +: 8] = sel[k] ? val[8*k +: 8] : old[8*k +: 8];
        end
    endfunction

    // Mask with one bit set for each supported filter
    function [15:0] fill_mask;
        input [3:0] n;
        integer k;
        begin
            for (k = 0; k < 16; k = k + 1)
                fill_mask[k] = (k < n);
        end
    endfunction

    // Supported counts, clamped to the largest filter sets
    always @* begin
        mac_sum = {2'h0, filt_cnt[`FC_UNI_LSB +: 4]}
            + {2'h0, filt_cnt[`FC_MUL_LSB +: 4]}
            + {2'h0, filt_cnt[`FC_MIX_LSB +: 4]};
        mac_n = (mac_sum > {2'h0, `MAX_MAC}) ? `MAX_MAC : mac_sum[3:0];
        vlan_n = filt_cnt[`FC_VLAN_LSB +: 4];
        mac_mask = fill_mask(mac_n);
        vlan_mask = fill_mask(vlan_n);
    end

    // Next variable byte: slots are already in unicast, multicast, mixed order
    always @* begin
        mac_cur = {mac_hi[mac_idx[2:0]], mac_lo[mac_idx[2:0]]};
        tag_cur = tag[tag_idx];
        have_byte = 1'b0;
        cur_byte = 8'h00;
        if (mac_idx < mac_n) begin
            have_byte = 1'b1;
            cur_byte = mac_cur[8*(`MAC_BYTES - mac_byte) +: 8];
        end else if (tag_idx < vlan_n) begin
            have_byte = 1'b1;
            cur_byte = tag_byte ? tag_cur[7:0] : tag_cur[15:8];
        end
    end

    // Word offered to the FIFO in the current state
    always @* begin
        push = 1'b0;
        push_data = 32'h00000000;
        push_last = 1'b0;
        case (state)
            S_FIXED: begin
                push = 1'b1;
                case (word_idx)
                    3'h0: push_data = resp_code;
                    3'h1: push_data = {4'h0, mac_n, 16'h0000,
                        mac_flags & mac_mask[7:0]};
                    3'h2: push_data = {4'h0, vlan_n, 8'h00, 1'b0,
                        vlan_flags & vlan_mask[14:0]};
                    3'h3: push_data = link_set;
                    3'h4: push_data = bcast_set;
                    3'h5: push_data = cfg_flags;
                    3'h6: push_data = {mode_fc[`MODE_LSB +: 8],
                        mode_fc[`FLOW_LSB +: 8], 16'h0000};
                    3'h7: push_data = evt_ctrl;
                    default: push_data = 32'h00000000;
                endcase
            end
            S_VAR: begin
                push = have_byte & (pos == 2'h3);
                push_data = {acc, cur_byte};
            end
            S_PAD: begin
                push = (pos == 2'h3);
                push_data = {acc, 8'h00};
            end
            S_CSUM: begin
                push = 1'b1;
                push_data = csum;
                push_last = 1'b1;
            end
            default: push = 1'b0;
        endcase
    end

    // Response framer; a full FIFO holds it in place
    always @(posedge clk_i) begin
        if (rst_i) begin
            state <= S_IDLE;
            pending <= 1'b0;
            word_idx <= 3'h0;
            mac_idx <= 4'h0;
            mac_byte <= 3'h0;
            tag_idx <= 4'h0;
            tag_byte <= 1'b0;
            pos <= 2'h0;
            acc <= 24'h000000;
            sent_cnt <= 8'h00;
            refused_cnt <= 8'h00;
        end else begin
            // A query during a build waits rather than being lost
            if (query_i & ~query_bad_i & (state != S_IDLE))
                pending <= 1'b1;
            if (query_i & query_bad_i)
                refused_cnt <= refused_cnt + 8'h01;
            if (step) begin
                case (state)
                    S_IDLE: begin
                        if ((query_i & ~query_bad_i) | pending) begin
                            state <= S_FIXED;
                            pending <= 1'b0;
                            word_idx <= 3'h0;
                            mac_idx <= 4'h0;
                            mac_byte <= 3'h0;
                            tag_idx <= 4'h0;
                            tag_byte <= 1'b0;
                            pos <= 2'h0;
                        end
                    end
                    S_FIXED: begin
                        word_idx <= word_idx + 3'h1;
                        if (word_idx == 3'h7)
                            state <= S_VAR;
                    end
                    S_VAR: begin
                        if (have_byte) begin
                            acc <= {acc[15:0], cur_byte};
                            pos <= pos + 2'h1;
                            if (mac_idx < mac_n) begin
                                if (mac_byte == `MAC_BYTES) begin
                                    mac_byte <= 3'h0;
                                    mac_idx <= mac_idx + 4'h1;
                                end else begin
                                    mac_byte <= mac_byte + 3'h1;
                                end
                            end else begin
                                tag_byte <= ~tag_byte;
                                if (tag_byte)
                                    tag_idx <= tag_idx + 4'h1;
                            end
                        end else if (pos != 2'h0) begin
                            state <= S_PAD;
                        end else begin
                            state <= S_CSUM;
                        end
                    end
                    S_PAD: begin
                        acc <= {acc[15:0], 8'h00};
                        pos <= pos + 2'h1;
                        if (pos == 2'h3)
                            state <= S_CSUM;
                    end
                    S_CSUM: begin
                        state <= S_IDLE;
                        sent_cnt <= sent_cnt + 8'h01;
                    end
                    default: state <= S_IDLE;
                endcase
            end
        end
    end

    // Settings writes; software must keep slots ordered by filter type
    always @(posedge clk_i) begin
        if (rst_i) begin
            filt_cnt <= 16'h0000;
            mac_flags <= 8'h00;
            vlan_flags <= 15'h0000;
            link_set <= `SET_RESET;
            bcast_set <= `SET_RESET;
            cfg_flags <= `SET_RESET;
            mode_fc <= 16'h0000;
            evt_ctrl <= `SET_RESET;
            csum <= `SET_RESET;
            resp_code <= `SET_RESET;
            for (i = 0; i < 8; i = i + 1) begin
                mac_lo[i] <= 32'h00000000;
                mac_hi[i] <= 16'h0000;
            end
            for (i = 0; i < 15; i = i + 1)
                tag[i] <= 16'h0000;
        end else if (wb_wr) begin
            case (adr_i)
                `REG_FILT_CNT: filt_cnt <= wr_val[15:0];
                `REG_MAC_FLAGS: mac_flags <= sel_i[0] ? dat_i[7:0] : mac_flags;
                `REG_VLAN_FLAGS: vlan_flags <= wr_val[14:0];
                `REG_LINK_SET: link_set <= merge(link_set, dat_i, sel_i);
                `REG_BCAST_SET: bcast_set <= merge(bcast_set, dat_i, sel_i);
                `REG_CFG_FLAGS: cfg_flags <= merge(cfg_flags, dat_i, sel_i);
                `REG_MODE_FC: mode_fc <= wr_val[15:0];
                `REG_EVT_CTRL: evt_ctrl <= merge(evt_ctrl, dat_i, sel_i);
                `REG_CSUM: csum <= merge(csum, dat_i, sel_i);
                `REG_RESP_CODE: resp_code <= merge(resp_code, dat_i, sel_i);
                default: begin
                    if (adr_i >= `REG_MAC_BASE && adr_i <= `REG_MAC_LAST) begin
                        if (adr_i[2])
                            mac_hi[adr_i[5:3]] <= wr_val[15:0];
                        else
                            mac_lo[adr_i[5:3]] <= wr_val;
                    end else if (adr_i >= `REG_TAG_BASE &&
                        adr_i <= `REG_TAG_LAST) begin
                        tag[adr_i[5:2]] <= wr_val[15:0];
                    end
                end
            endcase
        end
    end

    // Read mux; unmapped offsets answer zero rather than stall the bus
    always @* begin
        next_rdata = 32'h00000000;
        case (adr_i)
            `REG_STATUS: begin
                next_rdata[`ST_BUSY] = (state != S_IDLE);
                next_rdata[`ST_PEND] = pending;
                next_rdata[`ST_SENT_LSB +: 8] = sent_cnt;
                next_rdata[`ST_REFUSED_LSB +: 8] = refused_cnt;
            end
            `REG_FILT_CNT: next_rdata = {16'h0000, filt_cnt};
            `REG_MAC_FLAGS: next_rdata = {24'h000000, mac_flags};
            `REG_VLAN_FLAGS: next_rdata = {17'h00000, vlan_flags};
            `REG_LINK_SET: next_rdata = link_set;
            `REG_BCAST_SET: next_rdata = bcast_set;
            `REG_CFG_FLAGS: next_rdata = cfg_flags;
            `REG_MODE_FC: next_rdata = {16'h0000, mode_fc};
            `REG_EVT_CTRL: next_rdata = evt_ctrl;
            `REG_CSUM: next_rdata = csum;
            `REG_RESP_CODE: next_rdata = resp_code;
            default: begin
                if (adr_i >= `REG_MAC_BASE && adr_i <= `REG_MAC_LAST)
                    next_rdata = adr_i[2] ? {16'h0000, mac_hi[adr_i[5:3]]}
                        : mac_lo[adr_i[5:3]];
                else if (adr_i >= `REG_TAG_BASE && adr_i <= `REG_TAG_LAST)
                    next_rdata = {16'h0000, tag[adr_i[5:2]]};
            end
        endcase
    end

    // One wait state: ack and data registered, ack dropped after one cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= wb_req;
            if (wb_req & ~we_i)
                dat_o <= next_rdata;
        end
    end

    // Eight-word buffer between framer and sideband transmitter
    resp_fifo #(
        .WIDTH(33),
        .DEPTH(`OUT_FIFO_DEPTH),
        .AW(`OUT_FIFO_AW)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(push),
        .in_ready_o(fifo_ready),
        .in_data_i({push_last, push_data}),
        .out_valid_o(resp_valid_o),
        .out_ready_i(resp_ready_i),
        .out_data_o({resp_last_o, resp_data_o})
    );

endmodule
`default_nettype wire

// file: param_resp_chk.sv
// Port-level assertions for the parameter report response builder
`timescale 1ns/100ps
`default_nettype none

module param_resp_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone side
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Query and response stream
    input wire logic query_i,
    input wire logic query_bad_i,
    input wire logic resp_valid_o,
    input wire logic resp_ready_i,
    input wire logic [31:0] resp_data_o,
    input wire logic resp_last_o
);
    logic active, pend, take, good, hs;
    logic [4:0] idx;
    logic [7:0] mc, vc;

    assign take = cyc_i && stb_i && !ack_o;
    assign good = query_i && !query_bad_i;
    assign hs = resp_valid_o && resp_ready_i;

    // Track a build in flight, so start latency is judged only when idle
    always @(posedge clk_i) begin
        if (rst_i) begin
            active <= 1'b0;
            pend <= 1'b0;
        end else if (hs && resp_last_o) begin
            active <= pend || good;
            pend <= 1'b0;
        end else if (good && active) begin
            pend <= 1'b1;
        end else if (good) begin
            active <= 1'b1;
        end
    end

    // Word index within a packet, and the advertised counts
    always @(posedge clk_i) begin
        if (rst_i || (hs && resp_last_o))
            idx <= 5'h00;
        else if (hs)
            idx <= idx + 5'h01;
        if (hs && idx == 5'h01)
            mc <= resp_data_o[31:24];
        if (hs && idx == 5'h02)
            vc <= resp_data_o[31:24];
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_ACK_TAKE: assert property (take |=> ack_o)
        else $error("ack not one cycle after request");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    AST_UNMAPPED: assert property (take && !we_i && adr_i inside
        {[8'h2C:8'h3F]} |=> dat_o == 32'h0)
        else $error("unmapped read not zero");
    AST_HOLD: assert property (resp_valid_o && !resp_ready_i |=> resp_valid_o
        && $stable(resp_data_o) && $stable(resp_last_o))
        else $error("stream word changed while stalled");
    AST_START: assert property (good && !active |-> ##2 resp_valid_o)
        else $error("good query not answered in two cycles");
    AST_BAD: assert property (query_i && query_bad_i && !active &&
        !resp_valid_o |=> !resp_valid_o [*3])
        else $error("bad query produced words");
    AST_MAC_HDR: assert property (hs && idx == 5'h01 |-> resp_data_o[31:24]
        <= 8 && resp_data_o[23:8] == 16'h0 && (resp_data_o[7:0]
        >> resp_data_o[31:24]) == 8'h0)
        else $error("MAC count word malformed");
    AST_VLAN_HDR: assert property (hs && idx == 5'h02 |-> resp_data_o[31:24]
        <= 15 && resp_data_o[23:16] == 8'h0 && (resp_data_o[15:0]
        >> resp_data_o[31:24]) == 16'h0)
        else $error("VLAN count word malformed");
    AST_MODE: assert property (hs && idx == 5'h06 |->
        resp_data_o[15:0] == 16'h0)
        else $error("mode word low half not zero");
    AST_LENGTH: assert property (hs && resp_last_o |->
        idx == 8 + (6 * mc + 2 * vc + 3) / 4)
        else $error("packet length wrong for counts");
endmodule

bind param_resp_builder param_resp_chk chk (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o),
    .ack_o(ack_o), .query_i(query_i), .query_bad_i(query_bad_i),
    .resp_valid_o(resp_valid_o), .resp_ready_i(resp_ready_i),
    .resp_data_o(resp_data_o), .resp_last_o(resp_last_o));

`default_nettype wire

// file: param_resp_map.vh
// Register offsets, field positions, reset values and sizes of the builder
`ifndef PARAM_RESP_MAP_VH
`define PARAM_RESP_MAP_VH

// Wishbone register byte offsets
`define REG_STATUS      8'h00
`define REG_FILT_CNT    8'h04
`define REG_MAC_FLAGS   8'h08
`define REG_VLAN_FLAGS  8'h0C
`define REG_LINK_SET    8'h10
`define REG_BCAST_SET   8'h14
`define REG_CFG_FLAGS   8'h18
`define REG_MODE_FC     8'h1C
`define REG_EVT_CTRL    8'h20
`define REG_CSUM        8'h24
`define REG_RESP_CODE   8'h28
`define REG_MAC_BASE    8'h40
`define REG_MAC_LAST    8'h7C
`define REG_TAG_BASE    8'h80
`define REG_TAG_LAST    8'hB8

// Filter count register fields
`define FC_UNI_LSB      0
`define FC_MUL_LSB      4
`define FC_MIX_LSB      8
`define FC_VLAN_LSB     12

// Mode and flow control register fields
`define MODE_LSB        0
`define FLOW_LSB        8

// Status register fields
`define ST_BUSY         0
`define ST_PEND         1
`define ST_SENT_LSB     8
`define ST_REFUSED_LSB  16

// Filter limits
`define MAX_MAC         4'h8
`define MAX_VLAN        4'hF
`define MAC_BYTES       3'h5

// Reset value of every settings register
`define SET_RESET       32'h00000000

// Output FIFO shape
`define OUT_FIFO_DEPTH  8
`define OUT_FIFO_AW     3

`endif

// file: resp_fifo.v
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none

module resp_fifo #(
    parameter WIDTH = 33,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Filling side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // Draining side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire do_wr;
    wire do_rd;

    // Honest flags straight from the fill count
    assign in_ready_o = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != {(AW+1){1'b0}});
    assign out_data_o = mem[rd_ptr];
    assign do_wr = in_valid_i & in_ready_o;
    assign do_rd = out_valid_o & out_ready_i;

    // Pointers wrap naturally since depth is a power of two
    always @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (do_wr)
                wr_ptr <= wr_ptr + 1'b1;
            if (do_rd)
                rd_ptr <= rd_ptr + 1'b1;
            if (do_wr & ~do_rd)
                count <= count + 1'b1;
            else if (do_rd & ~do_wr)
                count <= count - 1'b1;
        end
    end

    // Storage has no reset; only entries below count are ever read
    always @(posedge clk_i) begin
        if (do_wr)
            mem[wr_ptr] <= in_data_i;
    end

endmodule
`default_nettype wire

// file: resp_sink.sv
// Management controller model that drains the response stream
`timescale 1ns/100ps
`default_nettype none

module resp_sink (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Response stream
    input wire logic valid_i,
    input wire logic [31:0] data_i,
    input wire logic last_i,
    output logic ready_o = 1'b0,
    // Bench control
    input wire logic stall_i
);
    logic [31:0] words[$];
    int n_last = 0;
    logic [2:0] tick;

    // Slow mode takes one word in eight, so the output FIFO backs up
    always @(posedge clk_i) begin
        if (rst_i) begin
            tick <= 3'h0;
            ready_o <= 1'b0;
        end else begin
            tick <= tick + 3'h1;
            ready_o <= !stall_i || tick == 3'h7;
            if (valid_i && ready_o) begin
                // Kept raw; enable flags decide later what is meaningful
                words.push_back(data_i);
                if (last_i)
                    n_last++;
            end
        end
    end
endmodule

`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the parameter report response builder
`timescale 1ns/100ps
`default_nettype none
`include "param_resp_map.vh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    miscompares++; $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
    end end

module tb_top;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
    logic we_i = 1'b0, query_i = 1'b0, query_bad_i = 1'b0, stall = 1'b1;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0, dat_o, resp_data_o, rd;
    logic ack_o, resp_valid_o, resp_ready_i, resp_last_o;
    logic [31:0] e[$];
    logic [7:0] ra[20] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
        8'h20, 8'h24, 8'h28, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h80,
        8'h84, 8'h88, 8'h30, 8'h3C};
    logic [31:0] rv[20] = '{32'h3011, 32'hFF, 32'h7FFF, 32'hA5A50001,
        32'hF, 32'hF, 32'h0103, 32'h7, 32'hDEADBEEF, 32'h00970000,
        32'h33445566, 32'h1122, 32'hCCDDEEFF, 32'hAABB, 32'h99999999,
        32'h0ABC, 32'h0DEF, 32'h0123, 32'hFFFFFFFF, 32'h5A5A5A5A};
    int miscompares = 0;
    int n_checks = 0;

    always #25 clk_i = ~clk_i;

    param_resp_builder dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .query_i(query_i),
        .query_bad_i(query_bad_i), .resp_valid_o(resp_valid_o),
        .resp_ready_i(resp_ready_i), .resp_data_o(resp_data_o),
        .resp_last_o(resp_last_o));

    resp_sink mdl (.clk_i(clk_i), .rst_i(rst_i), .valid_i(resp_valid_o),
        .data_i(resp_data_o), .last_i(resp_last_o), .ready_o(resp_ready_i),
        .stall_i(stall));

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One classic cycle; ack and read data are taken at the same rising edge
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1 && ++k < 20);
        if (ack_o !== 1'b1) begin
            miscompares++;
            conclude();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic ask(input logic bad);
        @(posedge clk_i);
        query_i <= 1'b1;
        query_bad_i <= bad;
        @(posedge clk_i);
        query_i <= 1'b0;
        query_bad_i <= 1'b0;
    endtask

    // Wait for a number of finished packets under a bound
    task automatic wait_last(input int nl);
        int k;
        for (k = 0; k < 3000 && mdl.n_last < nl; k++)
            @(posedge clk_i);
        if (mdl.n_last < nl) begin
            miscompares++;
            conclude();
        end
        repeat (20) @(posedge clk_i);
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, `REG_LINK_SET, 0);
        `CHK("link reset", `SET_RESET, rd)
        foreach (ra[i]) wb(1, ra[i], rv[i]);
        wb(0, 8'h30, 0);
        `CHK("unmapped", 32'h0, rd)
        wb(0, `REG_LINK_SET, 0);
        `CHK("link", 32'hA5A50001, rd)
        $display("test registers done");
        // Full packet while the controller stalls and the FIFO fills
        e = '{32'h00970000, 32'h02000003, 32'h03000007, 32'hA5A50001,
            32'hF, 32'hF, 32'h03010000, 32'h7, 32'h11223344, 32'h5566AABB,
            32'hCCDDEEFF, 32'h0ABC0DEF, 32'h01230000, 32'hDEADBEEF};
        ask(0);
        wait_last(1);
        `CHK("words", e.size(), mdl.words.size())
        foreach (e[i]) `CHK("word", e[i], mdl.words[i])
        $display("test full packet done");
        // Refused query leaves the stream silent and counts
        stall <= 1'b0;
        mdl.words.delete();
        ask(1);
        repeat (20) @(posedge clk_i);
        `CHK("bad words", 0, mdl.words.size())
        wb(0, `REG_STATUS, 0);
        `CHK("refused", 8'h01, rd[23:16])
        `CHK("sent", 8'h01, rd[15:8])
        $display("test refusal done");
        // No filters supported, two queries back to back
        wb(1, `REG_FILT_CNT, 0);
        e = '{32'h00970000, 32'h0, 32'h0, 32'hA5A50001, 32'hF, 32'hF,
            32'h03010000, 32'h7, 32'hDEADBEEF};
        ask(0);
        ask(0);
        wb(0, `REG_STATUS, 0);
        `CHK("busy pending", 2'h3, rd[1:0])
        wait_last(3);
        `CHK("words", 18, mdl.words.size())
        foreach (mdl.words[i]) `CHK("word", e[i % 9], mdl.words[i])
        $display("test pending query done");
        // Lanes 1 and 3 only; lanes above a narrow register are dropped
        sel_i <= 4'hA;
        wb(1, `REG_LINK_SET, 32'h11227700);
        wb(1, `REG_MODE_FC, 32'hFFFFAA00);
        sel_i <= 4'hF;
        wb(0, `REG_LINK_SET, 0);
        `CHK("lane link", 32'h11A57701, rd)
        wb(0, `REG_MODE_FC, 0);
        `CHK("lane mode", 32'h0000AA03, rd)
        $display("test byte lanes done");
        conclude();
    end
endmodule

`default_nettype wire
